// ---- host_port_pkg.sv ----
// constants, register map and types for the host port and general config
package host_port_pkg;

    // bus styles selected by the mode pins
    typedef enum logic [1:0] {
        MODE_SEP_I = 2'b00,
        MODE_MUX_I = 2'b01,
        MODE_SEP_M = 2'b10
    } bus_mode_type;

    // register addresses (16-bit address within the current page)
    localparam logic [15:0] ADDR_PAGE_SELECT = 16'hFFFF;
    localparam logic [7:0]  GEN_PAGE         = 8'h00;
    localparam logic [15:0] ADDR_IRQ_LOW     = 16'h0000;
    localparam logic [15:0] ADDR_IRQ_HIGH    = 16'h0001;
    localparam logic [15:0] ADDR_GEN_CTRL    = 16'h0002;
    localparam logic [15:0] ADDR_GEN_STATUS  = 16'h0003;
    localparam logic [15:0] ADDR_GEN_DELTA   = 16'h0004;
    localparam logic [15:0] ADDR_GEN_MASK    = 16'h0005;
    localparam logic [15:0] ADDR_PLL_DIV     = 16'h0006;
    localparam logic [15:0] ADDR_PLL_BW      = 16'h0007;

    // control register fields
    localparam int CTRL_SOFT_RESET = 0;
    localparam int CTRL_SWAP_REQ   = 1;
    localparam int CTRL_LOCKOUT    = 2;
    localparam int CTRL_HOLD       = 3;

    // status / delta / mask fields
    localparam int EV_LOCK_LOST = 0;
    localparam int EV_REF_LOST  = 1;
    localparam int EV_SWAP_REQ  = 2;
    localparam int EV_SWAP_BUSY = 3;
    localparam int ST_SWAP_BUSY = 2;

    // summary bits
    localparam int SUM_GEN      = 0;
    localparam int SUM_USED     = 10;

    // reset values
    localparam logic [7:0] PAGE_RESET = 8'h00;
    localparam logic [2:0] DIV_RESET  = 3'h0;
    localparam logic [9:0] BW_RESET   = 10'h200;
    localparam logic [3:0] MASK_RESET = 4'h0;

    // timing
    localparam int CLK_PERIOD_PS   = 8000;
    localparam int FRAME_PERIOD_NS = 125000;
    localparam int FRAME_CYCLES    = FRAME_PERIOD_NS * 1000 / CLK_PERIOD_PS;
    localparam int PULSE_CYCLES    = 4;
    localparam int BLACKOUT_CYCLES = 8;
    localparam int FRAME_CNT_W     = 14;

endpackage

// ---- host_bus_decode.sv ----
// strobe decoder for the three host bus styles
`timescale 1ns/10ps
module host_bus_decode (
    // clock and reset
    input  wire logic        clk_sys,
    input  wire logic        rst,
    // host pins
    input  wire logic [1:0]  cpu_mode,
    input  wire logic        csn,
    input  wire logic        rd_wrn,
    input  wire logic        write_data_strobe,
    input  wire logic        addr_strobe_latch,
    input  wire logic [15:0] a,
    input  wire logic [15:0] d_in,
    // decoded access
    output logic             wr_pulse,
    output logic             rd_pulse,
    output logic             rd_active,
    output logic [15:0]      addr,
    output logic [15:0]      wdata
);

    typedef struct packed {
        logic        rd_q;
        logic        ds_q;
        logic        as_q;
        logic        wr;
        logic        rd;
        logic        act;
        logic [15:0] addr;
        logic [15:0] wdata;
    } dec_state_type;

    dec_state_type st_reg;
    dec_state_type st_next;

    always_comb begin
        st_next = st_reg;
        st_next.rd_q = rd_wrn;
        st_next.ds_q = write_data_strobe;
        st_next.as_q = addr_strobe_latch;
        st_next.wr = 1'b0;
        st_next.rd = 1'b0;
        st_next.act = 1'b0;
        unique case (cpu_mode)
            host_port_pkg::MODE_SEP_I: begin
                // write on rising data strobe
                if (!csn && rd_wrn && addr_strobe_latch && write_data_strobe
                    && !st_reg.ds_q) begin
                    st_next.wr = 1'b1;
                    st_next.addr = a;
                    st_next.wdata = d_in;
                end
                if (!csn && !rd_wrn && st_reg.rd_q && write_data_strobe
                    && addr_strobe_latch) begin
                    st_next.rd = 1'b1;
                    st_next.addr = a;
                end
                st_next.act = !csn && !rd_wrn;
            end
            host_port_pkg::MODE_MUX_I: begin
                if (!csn && !addr_strobe_latch && st_reg.as_q) begin
                    st_next.addr = d_in;
                end
                if (!csn && rd_wrn && !addr_strobe_latch && write_data_strobe
                    && !st_reg.ds_q) begin
                    st_next.wr = 1'b1;
                    st_next.wdata = d_in;
                end
                if (!csn && !rd_wrn && st_reg.rd_q && write_data_strobe
                    && !addr_strobe_latch) begin
                    st_next.rd = 1'b1;
                end
                st_next.act = !csn && !rd_wrn;
            end
            host_port_pkg::MODE_SEP_M: begin
                if (!csn && addr_strobe_latch && !st_reg.as_q) begin
                    st_next.addr = a;
                end
                if (!csn && addr_strobe_latch && write_data_strobe
                    && !st_reg.ds_q) begin
                    st_next.wr = !rd_wrn;
                    st_next.rd = rd_wrn;
                    st_next.wdata = d_in;
                end
                st_next.act = st_next.rd || (st_reg.act && !csn && rd_wrn);
            end
            default: begin
                st_next.act = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            st_reg <= '{rd_q: 1'b1, ds_q: 1'b1, as_q: 1'b1, wr: 1'b0,
                        rd: 1'b0, act: 1'b0, addr: 16'h0000,
                        wdata: 16'h0000};
        end else begin
            st_reg <= st_next;
        end
    end

    assign wr_pulse  = st_reg.wr;
    assign rd_pulse  = st_reg.rd;
    assign rd_active = st_reg.act;
    assign addr      = st_reg.addr;
    assign wdata     = st_reg.wdata;

endmodule

// ---- swap_request.sv ----
// configuration swap request timing toward the switch core
`timescale 1ns/10ps
module swap_request #(
    parameter int FRAME_CYCLES = host_port_pkg::FRAME_CYCLES
) (
    // clock and reset
    input  wire logic clk_sys,
    input  wire logic rst,
    // request sources and controls
    input  wire logic swap_pin,
    input  wire logic swap_cmd,
    input  wire logic swap_lockout,
    input  wire logic transparent_mode,
    input  wire logic frame_boundary,
    // results
    output logic      swap_pulse,
    output logic      swap_busy,
    output logic      req_event,
    output logic      busy_fall_event
);

    localparam logic [host_port_pkg::FRAME_CNT_W-1:0] BLACK_START =
        host_port_pkg::FRAME_CNT_W'(FRAME_CYCLES
                                    - host_port_pkg::BLACKOUT_CYCLES);
    localparam logic [host_port_pkg::FRAME_CNT_W-1:0] FRAME_LAST =
        host_port_pkg::FRAME_CNT_W'(FRAME_CYCLES - 1);
    localparam logic [2:0] PULSE_LAST =
        3'(host_port_pkg::PULSE_CYCLES);

    typedef struct packed {
        logic                                  pin_q;
        logic                                  pending;
        logic                                  pulsing;
        logic [2:0]                            pcnt;
        logic                                  pulse;
        logic                                  busy;
        logic                                  req_ev;
        logic                                  fall_ev;
        logic [host_port_pkg::FRAME_CNT_W-1:0] fcnt;
    } swap_state_type;

    swap_state_type st_reg;
    swap_state_type st_next;

    logic request;
    logic blackout;

    always_comb begin
        request  = (swap_pin && !st_reg.pin_q) || swap_cmd;
        blackout = st_reg.fcnt >= BLACK_START;
        st_next = st_reg;
        st_next.pin_q = swap_pin;
        st_next.req_ev = request;
        st_next.fall_ev = 1'b0;
        st_next.pulse = 1'b0;
        if (frame_boundary) begin
            st_next.fcnt = '0;
        end else if (st_reg.fcnt != FRAME_LAST) begin
            st_next.fcnt = st_reg.fcnt + 1'b1;
        end
        if (request) begin
            st_next.pending = 1'b1;
        end
        if (st_reg.pulsing) begin
            st_next.pulse = 1'b1;
            st_next.pcnt = st_reg.pcnt + 1'b1;
            if (st_reg.pcnt == PULSE_LAST) begin
                st_next.pulsing = 1'b0;
                st_next.pulse = 1'b0;
            end
        end else if ((st_reg.pending || request) && !blackout) begin
            st_next.pending = 1'b0;
            if (!swap_lockout) begin
                st_next.pulsing = 1'b1;
                st_next.pulse = 1'b1;
                st_next.pcnt = 3'h1;
                st_next.busy = 1'b1;
            end
        end
        // busy ends at the boundary, or at pulse end in transparent mode
        if (st_reg.busy && !st_next.pulsing
            && (frame_boundary || transparent_mode)) begin
            st_next.busy = 1'b0;
            st_next.fall_ev = 1'b1;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign swap_pulse      = st_reg.pulse;
    assign swap_busy       = st_reg.busy;
    assign req_event       = st_reg.req_ev;
    assign busy_fall_event = st_reg.fall_ev;

endmodule

// ---- host_port_general_config.sv ----
// host processor port with device-wide configuration registers
//
// Summary of operation
// - port logic needs no device or PLL clock
// - write to 0xFFFF loads the page register
// - two summary registers, interrupt pin low if any
// - delta set on status change, masked into interrupt
// - summary bit map: config, receivers, transmitters, parity
// - reset pin and soft reset bit reset device
// - lock lost and reference lost with delta, mask
// - three-bit divide and ten-bit bandwidth fields
// - pin or bit request, four-cycle core pulse
// - any request sets swap request delta
// - lockout blocks pulses, deltas still work
// - blackout before boundary delays request pulse
// - busy until boundary, falling edge sets delta
// - hold copies writes; transparent swaps immediately
// - mode pins pick one of three bus styles
// - separate style write on rising write strobe
// - separate style read after falling read strobe
// - multiplexed style latches address on latch fall
// - multiplexed write on strobe rise, read on fall
// - third style latches address on strobe rise
// - third style data strobe rise writes or reads
`timescale 1ns/10ps
module host_port_general_config #(
    parameter int FRAME_CYCLES = host_port_pkg::FRAME_CYCLES
) (
    // clock and reset
    input  wire logic        clk_sys,
    input  wire logic        rst,
    // host bus pins
    input  wire logic [1:0]  cpu_mode,
    input  wire logic        csn,
    input  wire logic        rd_wrn,
    input  wire logic        write_data_strobe,
    input  wire logic        addr_strobe_latch,
    input  wire logic [15:0] a,
    input  wire logic [15:0] d_in,
    output logic      [15:0] d_out,
    output logic             d_oe_n,
    output logic             irq_n,
    // full internal address toward block registers
    output logic      [23:0] int_addr,
    // clock multiplier status and control
    input  wire logic        pll_lock_lost,
    input  wire logic        pll_ref_lost,
    output logic      [2:0]  pll_divide_sel,
    output logic      [9:0]  pll_loop_bandwidth,
    // other blocks' interrupt subgroups, summary bits 1 to 9
    input  wire logic [8:0]  block_irq,
    // soft reset toward the device
    output logic             soft_reset_out,
    // switch core configuration swap
    input  wire logic        swap_pin,
    input  wire logic        frame_boundary,
    input  wire logic        transparent_mode,
    output logic             swap_pulse,
    output logic             swap_passthrough_hold
);

    typedef struct packed {
        logic [7:0]  page;
        logic        soft_rst;
        logic        swap_cmd;
        logic        lockout;
        logic        hold;
        logic        lol_q;
        logic        lor_q;
        logic [3:0]  delta;
        logic [3:0]  mask;
        logic [2:0]  div;
        logic [9:0]  bw;
        logic [15:0] rdata;
        logic        oe_n;
        logic        irq_n;
        logic [23:0] full_addr;
    } cfg_state_type;

    cfg_state_type st_reg;
    cfg_state_type st_next;

    logic        wr_pulse;
    logic        rd_pulse;
    logic        rd_active;
    logic [15:0] addr16;
    logic [15:0] wdata;
    logic        swap_busy;
    logic        req_event;
    logic        busy_fall_event;
    logic [3:0]  irq_enable;
    logic        gen_irq;
    logic [15:0] summary_low;

    // bus style decode, sampled on clk_sys only
    host_bus_decode u_dec (
        .clk_sys           (clk_sys),
        .rst               (rst),
        .cpu_mode          (cpu_mode),
        .csn               (csn),
        .rd_wrn            (rd_wrn),
        .write_data_strobe (write_data_strobe),
        .addr_strobe_latch (addr_strobe_latch),
        .a                 (a),
        .d_in              (d_in),
        .wr_pulse          (wr_pulse),
        .rd_pulse          (rd_pulse),
        .rd_active         (rd_active),
        .addr              (addr16),
        .wdata             (wdata)
    );

    swap_request #(
        .FRAME_CYCLES (FRAME_CYCLES)
    ) u_swap (
        .clk_sys          (clk_sys),
        .rst              (rst),
        .swap_pin         (swap_pin),
        .swap_cmd         (st_reg.swap_cmd),
        .swap_lockout     (st_reg.lockout),
        .transparent_mode (transparent_mode),
        .frame_boundary   (frame_boundary),
        .swap_pulse       (swap_pulse),
        .swap_busy        (swap_busy),
        .req_event        (req_event),
        .busy_fall_event  (busy_fall_event)
    );

    // true when the access hits a general register on the config page
    function automatic logic gen_hit(input logic [7:0]  page,
                                     input logic [15:0] adr,
                                     input logic [15:0] target);
        gen_hit = (page == host_port_pkg::GEN_PAGE) && (adr == target);
    endfunction

    always_comb begin
        // lock and busy masks block when set; request mask enables
        irq_enable = ~st_reg.mask;
        irq_enable[host_port_pkg::EV_SWAP_REQ] =
            st_reg.mask[host_port_pkg::EV_SWAP_REQ];
        gen_irq = |(st_reg.delta & irq_enable);
        summary_low = 16'h0000;
        summary_low[host_port_pkg::SUM_GEN] = gen_irq;
        summary_low[host_port_pkg::SUM_USED-1:1] = block_irq;
    end

    always_comb begin
        st_next = st_reg;
        st_next.swap_cmd = 1'b0;
        st_next.lol_q = pll_lock_lost;
        st_next.lor_q = pll_ref_lost;
        st_next.full_addr = {st_reg.page, addr16};

        // register writes, always whole words
        if (wr_pulse) begin
            if (addr16 == host_port_pkg::ADDR_PAGE_SELECT) begin
                st_next.page = wdata[7:0];
            end else if (gen_hit(st_reg.page, addr16,
                                 host_port_pkg::ADDR_GEN_CTRL)) begin
                st_next.soft_rst =
                    wdata[host_port_pkg::CTRL_SOFT_RESET];
                st_next.swap_cmd =
                    wdata[host_port_pkg::CTRL_SWAP_REQ];
                st_next.lockout = wdata[host_port_pkg::CTRL_LOCKOUT];
                st_next.hold = wdata[host_port_pkg::CTRL_HOLD];
            end else if (gen_hit(st_reg.page, addr16,
                                 host_port_pkg::ADDR_GEN_DELTA)) begin
                st_next.delta = st_reg.delta & ~wdata[3:0];
            end else if (gen_hit(st_reg.page, addr16,
                                 host_port_pkg::ADDR_GEN_MASK)) begin
                st_next.mask = wdata[3:0];
            end else if (gen_hit(st_reg.page, addr16,
                                 host_port_pkg::ADDR_PLL_DIV)) begin
                st_next.div = wdata[2:0];
            end else if (gen_hit(st_reg.page, addr16,
                                 host_port_pkg::ADDR_PLL_BW)) begin
                st_next.bw = wdata[9:0];
            end
        end

        // events set deltas after any clear, so a set wins
        if (pll_lock_lost != st_reg.lol_q) begin
            st_next.delta[host_port_pkg::EV_LOCK_LOST] = 1'b1;
        end
        if (pll_ref_lost != st_reg.lor_q) begin
            st_next.delta[host_port_pkg::EV_REF_LOST] = 1'b1;
        end
        if (req_event) begin
            st_next.delta[host_port_pkg::EV_SWAP_REQ] = 1'b1;
        end
        if (busy_fall_event) begin
            st_next.delta[host_port_pkg::EV_SWAP_BUSY] = 1'b1;
        end

        // read data captured once per access
        if (rd_pulse) begin
            st_next.rdata = 16'h0000;
            if (addr16 == host_port_pkg::ADDR_PAGE_SELECT) begin
                st_next.rdata = {8'h00, st_reg.page};
            end else if (gen_hit(st_reg.page, addr16,
                                 host_port_pkg::ADDR_IRQ_LOW)) begin
                st_next.rdata = summary_low;
            end else if (gen_hit(st_reg.page, addr16,
                                 host_port_pkg::ADDR_GEN_CTRL)) begin
                st_next.rdata = {12'h000, st_reg.hold, st_reg.lockout,
                                 1'b0, st_reg.soft_rst};
            end else if (gen_hit(st_reg.page, addr16,
                                 host_port_pkg::ADDR_GEN_STATUS)) begin
                st_next.rdata = {13'h0000, swap_busy, st_reg.lor_q,
                                 st_reg.lol_q};
            end else if (gen_hit(st_reg.page, addr16,
                                 host_port_pkg::ADDR_GEN_DELTA)) begin
                st_next.rdata = {12'h000, st_reg.delta};
            end else if (gen_hit(st_reg.page, addr16,
                                 host_port_pkg::ADDR_GEN_MASK)) begin
                st_next.rdata = {12'h000, st_reg.mask};
            end else if (gen_hit(st_reg.page, addr16,
                                 host_port_pkg::ADDR_PLL_DIV)) begin
                st_next.rdata = {13'h0000, st_reg.div};
            end else if (gen_hit(st_reg.page, addr16,
                                 host_port_pkg::ADDR_PLL_BW)) begin
                st_next.rdata = {6'h00, st_reg.bw};
            end
        end

        // drive the bus only during a read with chip select low
        st_next.oe_n = !((rd_active || rd_pulse) && !csn);
        st_next.irq_n = !(|summary_low);
    end

    // port state depends only on clk_sys and rst
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            st_reg <= '{page: host_port_pkg::PAGE_RESET, soft_rst: 1'b0,
                        swap_cmd: 1'b0, lockout: 1'b0, hold: 1'b0,
                        lol_q: 1'b0, lor_q: 1'b0, delta: 4'h0,
                        mask: host_port_pkg::MASK_RESET,
                        div: host_port_pkg::DIV_RESET,
                        bw: host_port_pkg::BW_RESET, rdata: 16'h0000,
                        oe_n: 1'b1, irq_n: 1'b1, full_addr: 24'h000000};
        end else begin
            st_reg <= st_next;
        end
    end

    assign d_out                 = st_reg.rdata;
    assign d_oe_n                = st_reg.oe_n;
    assign irq_n                 = st_reg.irq_n;
    assign int_addr              = st_reg.full_addr;
    assign pll_divide_sel        = st_reg.div;
    assign pll_loop_bandwidth    = st_reg.bw;
    assign soft_reset_out        = st_reg.soft_rst;
    assign swap_passthrough_hold = st_reg.hold;

endmodule

// ---- hpgc_sva.sv ----
// assertions on the host port and swap pins
`timescale 1ns/10ps
module hpgc_sva #(
    parameter int FRAME_CYCLES = 64
) (
    // clock, reset and host pins
    input wire logic        clk_sys,
    input wire logic        rst,
    input wire logic [1:0]  cpu_mode,
    input wire logic        csn,
    input wire logic        rd_wrn,
    input wire logic        write_data_strobe,
    input wire logic        addr_strobe_latch,
    input wire logic [15:0] a,
    input wire logic [15:0] d_in,
    input wire logic        d_oe_n,
    input wire logic        irq_n,
    // register outputs and swap
    input wire logic [23:0] int_addr,
    input wire logic [2:0]  pll_divide_sel,
    input wire logic [8:0]  block_irq,
    input wire logic        soft_reset_out,
    input wire logic        frame_boundary,
    input wire logic        swap_pulse
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    logic sel0;
    assign sel0 = !csn && addr_strobe_latch && cpu_mode == 2'h0;
    chk_pulse_len: assert property (
        $rose(swap_pulse) |-> swap_pulse[*4] ##1 !swap_pulse)
        else $error("swap pulse not four cycles");
    chk_no_overlap: assert property (
        frame_boundary |-> !swap_pulse)
        else $error("swap pulse meets frame boundary");
    chk_irq_pin: assert property (
        |block_irq |=> !irq_n)
        else $error("interrupt pin not low");
    chk_bus_idle: assert property (
        csn[*3] |-> d_oe_n)
        else $error("data bus driven while deselected");
    chk_page_load: assert property (
        $rose(write_data_strobe) && sel0 && rd_wrn && a == 16'hFFFF
        |-> ##3 int_addr[23:16] == $past(d_in[7:0], 3))
        else $error("page register not loaded");
    chk_div_load: assert property (
        $rose(write_data_strobe) && sel0 && rd_wrn && a == 16'h0006
        && int_addr[23:16] == 8'h00
        |-> ##2 pll_divide_sel == $past(d_in[2:0], 2))
        else $error("divide field not loaded");
    chk_srst_load: assert property (
        $rose(write_data_strobe) && sel0 && rd_wrn && a == 16'h0002
        && int_addr[23:16] == 8'h00
        |-> ##2 soft_reset_out == $past(d_in[0], 2))
        else $error("soft reset output wrong");
    chk_read_sep: assert property (
        $fell(rd_wrn) && sel0 && write_data_strobe |-> ##2 !d_oe_n)
        else $error("read data not driven");
    chk_read_dir: assert property (
        $rose(write_data_strobe) && !csn && rd_wrn && addr_strobe_latch
        && cpu_mode == 2'h2 |-> ##2 !d_oe_n)
        else $error("strobe read data not driven");
endmodule
bind host_port_general_config hpgc_sva #(.FRAME_CYCLES(FRAME_CYCLES)) u_sva (
    .clk_sys, .rst, .cpu_mode, .csn, .rd_wrn, .write_data_strobe,
    .addr_strobe_latch, .a, .d_in, .d_oe_n, .irq_n, .int_addr,
    .pll_divide_sel, .block_irq, .soft_reset_out, .frame_boundary,
    .swap_pulse);

// ---- host_cpu_model.sv ----
// host controller driving the parallel port pins
`timescale 1ns/10ps
module host_cpu_model (
    // clock and bus style
    input  wire logic        clk_sys,
    input  wire logic [1:0]  mode,
    // bus pins
    output logic             csn,
    output logic             rd_wrn,
    output logic             write_data_strobe,
    output logic             addr_strobe_latch,
    output logic [15:0]      a,
    output logic [15:0]      d_in,
    input  wire logic [15:0] d_out,
    input  wire logic        d_oe_n
);
    initial begin
        {csn, rd_wrn, write_data_strobe, addr_strobe_latch} = 4'hF;
        {a, d_in} = 32'h00000000;
    end
    // one whole-word access
    task automatic acc(input logic w, input logic [15:0] ad, dt,
                       output logic [15:0] q);
        int n;
        q = 16'h0000;
        n = 0;
        @(negedge clk_sys);
        csn <= 1'h0;
        a <= ad;
        d_in <= ad;
        addr_strobe_latch <= (mode != 2'h2);
        @(negedge clk_sys);
        addr_strobe_latch <= (mode != 2'h1);
        @(negedge clk_sys);
        d_in <= w ? dt : ~ad;
        write_data_strobe <= !(w || mode == 2'h2);
        rd_wrn <= (w == (mode != 2'h2));
        @(negedge clk_sys);
        write_data_strobe <= 1'h1;
        while (!w && d_oe_n && n < 8) begin
            @(negedge clk_sys);
            n++;
        end
        q = d_out;
        @(negedge clk_sys);
        csn <= 1'h1;
        rd_wrn <= 1'h1;
        addr_strobe_latch <= 1'h1;
        d_in <= ~d_in;
        repeat (2) @(negedge clk_sys);
    endtask
endmodule

// ---- host_port_general_config_tb.sv ----
// self-checking bench for the host port and general config
`timescale 1ns/10ps
module host_port_general_config_tb;
    localparam int FR = 64;
    logic        clk_sys, rst, csn, rd_wrn, write_data_strobe, irq_n;
    logic        addr_strobe_latch, d_oe_n, pll_lock_lost, pll_ref_lost;
    logic        soft_reset_out, swap_pin, frame_boundary, swap_pulse;
    logic        swap_passthrough_hold, oe_q, pls_q;
    logic [1:0]  cpu_mode;
    logic [15:0] a, d_in, d_out, v, q;
    logic [23:0] int_addr;
    logic [2:0]  pll_divide_sel;
    logic [9:0]  pll_loop_bandwidth;
    logic [8:0]  block_irq;
    logic [31:0] seed = 32'h00000005;
    int          miscompares = 0, samples_checked = 0, pulses = 0, fcnt = 0;
    logic [15:0] exp_q[$];
    string       name_q[$];
    host_cpu_model cpu (.clk_sys, .mode(cpu_mode), .csn, .rd_wrn,
        .write_data_strobe, .addr_strobe_latch, .a, .d_in, .d_out, .d_oe_n);
    host_port_general_config #(.FRAME_CYCLES(FR)) uut (.clk_sys, .rst,
        .cpu_mode, .csn, .rd_wrn, .write_data_strobe, .addr_strobe_latch,
        .a, .d_in, .d_out, .d_oe_n, .irq_n, .int_addr, .pll_lock_lost,
        .pll_ref_lost, .pll_divide_sel, .pll_loop_bandwidth, .block_irq,
        .soft_reset_out, .swap_pin, .frame_boundary,
        .transparent_mode(1'h0), .swap_pulse, .swap_passthrough_hold);
    function automatic logic [15:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[15:0];
    endfunction
    task automatic chk(input string nm, input logic [15:0] e, s);
        samples_checked++;
        if (s !== e) begin
            miscompares++;
            $display("BAD %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic rd(input logic [15:0] ad, e, input string nm);
        exp_q.push_back(e);
        name_q.push_back(nm);
        cpu.acc(1'h0, ad, 16'h0000, q);
    endtask
    task automatic wr(input logic [15:0] ad, dt);
        cpu.acc(1'h1, ad, dt, q);
    endtask
    task automatic give_verdict;
        if (exp_q.size() != 0)
            miscompares++;
        $display("checked %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        clk_sys = 1'h0;
        forever #4 clk_sys = ~clk_sys;
    end
    // frame pulse and result watcher
    always @(negedge clk_sys) begin
        fcnt <= (fcnt == FR - 1) ? 0 : fcnt + 1;
        frame_boundary <= (fcnt == FR - 1);
        if (!d_oe_n && oe_q && exp_q.size() > 0)
            chk(name_q.pop_front(), exp_q.pop_front(), d_out);
        if (swap_pulse && !pls_q)
            pulses++;
        oe_q = d_oe_n;
        pls_q = swap_pulse;
    end
    initial begin
        repeat (20000) @(posedge clk_sys);
        miscompares++;
        give_verdict;
    end
    initial begin
        rst = 1'h1;
        {pll_lock_lost, pll_ref_lost, swap_pin} = 3'h0;
        cpu_mode = 2'h0;
        block_irq = 9'h000;
        repeat (6) @(posedge clk_sys);
        @(negedge clk_sys) rst <= 1'h0;
        rd(16'h0007, 16'h0200, "bw_reset");
        for (int m = 0; m < 3; m++) begin
            cpu_mode = m[1:0];
            v = xs();
            wr(16'h0006, v);
            rd(16'h0006, {13'h0000, v[2:0]}, "divide");
            wr(16'h0007, v);
            rd(16'h0007, {6'h00, v[9:0]}, "bandwidth");
            wr(16'hFFFF, 16'h0080 | v);
            rd(16'h0006, 16'h0000, "other_page");
            wr(16'hFFFF, 16'h0000);
        end
        cpu_mode = 2'h0;
        block_irq = 9'(xs()) | 9'h001;
        rd(16'h0000, {6'h00, block_irq, 1'h0}, "summary");
        rd(16'h0001, 16'h0000, "summary_high");
        block_irq = 9'h000;
        {pll_lock_lost, pll_ref_lost} = 2'h3;
        rd(16'h0003, 16'h0003, "status");
        rd(16'h0004, 16'h0003, "delta");
        rd(16'h0000, 16'h0001, "summary_gen");
        wr(16'h0005, 16'h0003);
        rd(16'h0000, 16'h0000, "masked");
        wr(16'h0004, 16'h000F);
        wr(16'h0002, 16'h0004);
        swap_pin = 1'h1;
        rd(16'h0004, 16'h0004, "lock_delta");
        swap_pin = 1'h0;
        rd(16'h0002, 16'h0004, "ctrl");
        wr(16'h0002, (q & 16'hFFFB) | 16'h0002);
        repeat (140) @(negedge clk_sys);
        rd(16'h0004, 16'h000C, "swap_delta");
        rd(16'h0000, 16'h0001, "busy_irq");
        chk("pulses", 16'h0001, 16'(pulses));
        wr(16'h0002, 16'h0009);
        rd(16'h0002, 16'h0009, "srst_on");
        chk("outs", {6'h01, v[9:0]},
            {6'(swap_passthrough_hold), pll_loop_bandwidth});
        wr(16'h0002, 16'h0000);
        give_verdict;
    end
endmodule
